// ### pkg/ddp_pkg.sv
// Package with the address map, field layout and encodings of the dual data pointer unit.
package ddp_pkg;

   // Width of each data pointer and of the special function register bus.
   localparam int PTR_W  = 24;
   localparam int SFR_AW = 8;
   localparam int SFR_DW = 8;

   // Special function register addresses.
   localparam logic [7:0] ADDR_PTR_CTL  = 8'ha7;
   localparam logic [7:0] ADDR_PTR_LOW  = 8'h82;
   localparam logic [7:0] ADDR_PTR_HIGH = 8'h83;
   localparam logic [7:0] ADDR_PTR_PAGE = 8'h84;

   // Pointer control register layout and power-on value.
   localparam int          CTL_SEL_BIT    = 0;
   localparam int          CTL_UNUSED_BIT = 1;
   localparam int          CTL_MMODE_LSB  = 2;
   localparam int          CTL_SMODE_LSB  = 4;
   localparam int          CTL_SWAP_BIT   = 6;
   localparam int          CTL_RSVD_BIT   = 7;
   localparam logic [7:0]  CTL_RESET      = 8'h00;
   localparam logic [23:0] PTR_RESET      = 24'h000000;
   localparam logic [7:0]  UNMAPPED_DATA  = 8'h00;

   // Byte positions of the pointer byte registers inside a pointer.
   localparam int LOW_LSB  = 0;
   localparam int HIGH_LSB = 8;
   localparam int PAGE_LSB = 16;

   // Per-pointer post-access modification modes.
   typedef enum logic [1:0] {
      DDP_MODE_STD = 2'h0,
      DDP_MODE_INC = 2'h1,
      DDP_MODE_DEC = 2'h2,
      DDP_MODE_TOG = 2'h3
   } ddp_mode_e;

   // Kind of external memory or code memory move reported by the core.
   typedef enum logic [1:0] {
      DDP_XFER_MOVC_ACTIVE_DATA_POINTER = 2'h0,
      DDP_XFER_MOVX_ACTIVE_DATA_POINTER = 2'h1,
      DDP_XFER_MOVC_PC   = 2'h2,
      DDP_XFER_MOVX_RI   = 2'h3
   } ddp_xfer_e;

endpackage

// ### pkg/ddp_step_if.sv
// Interface that carries one pointer and its mode to a post-access step unit.
`timescale 1ns/1ps
interface ddp_step_if #(
   parameter int W = 24
);
   import ddp_pkg::*;

   ddp_mode_e      mode;
   logic [W-1:0]   cur;
   logic [W-1:0]   nxt;

   modport calc (input mode, input cur, output nxt);
   modport user (output mode, output cur, input nxt);
endinterface

// ### hdl/ddp_step.sv
// Post-access modification of one data pointer: keep, increment, decrement or toggle bit 0.
`timescale 1ns/1ps
module ddp_step #(
   parameter int W = 24
) (
   // Pointer and mode in, modified pointer out.
   ddp_step_if.calc   st
);
   import ddp_pkg::*;

   localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

   // The carry runs across the whole width, so a page boundary is crossed without help.
   always_comb begin
      case (st.mode)
         DDP_MODE_STD: st.nxt = st.cur;
         DDP_MODE_INC: st.nxt = st.cur + ONE;
         DDP_MODE_DEC: st.nxt = st.cur - ONE;
         DDP_MODE_TOG: st.nxt = {st.cur[W-1:1], ~st.cur[0]};
         default:      st.nxt = st.cur;
      endcase
   end

endmodule

// ### hdl/ddp_top.sv
// Dual data pointer unit: control register, two pointers and the post-access logic.
`timescale 1ns/1ps
import ddp_pkg::*;

// Functional notes
// - Two independent pointers exist, main and shadow, chosen by the control register.
// - Power-on clears the control register: main active, standard modes, no swapping.
// - With bit 6 set the active pointer flips after each qualifying move.
// - Bits 5:4 set shadow pointer behaviour: keep, increment, decrement, toggle bit 0.
// - Bits 3:2 give the main pointer the same four behaviours.
// - Both pointers are 24 bits; the selected one appears in low, high, page bytes.
// - Bit 0 clear shows the main pointer, bit 0 set shows the shadow pointer.
// - Bit 1 is absent, so incrementing the register just flips the select bit.
// - Only code and external moves through the pointer modify it; others leave both.
// - Every other pointer reference works on the pointer currently selected.
module ddp_top #(
   parameter int PW = ddp_pkg::PTR_W
) (
   // Clock and reset.
   input  wire logic                       sys_clk,
   input  wire logic                       rst_b,
   // Special function register bus from the core.
   input  wire logic [ddp_pkg::SFR_AW-1:0] sfr_addr,
   input  wire logic                       sfr_wr,
   input  wire logic                       sfr_rd,
   input  wire logic [ddp_pkg::SFR_DW-1:0] sfr_wdata,
   output logic      [ddp_pkg::SFR_DW-1:0] sfr_rdata_q,
   output logic                            sfr_hit_q,
   // Instruction events from the core.
   input  wire logic                       xfer_valid,
   input  wire ddp_pkg::ddp_xfer_e         xfer_kind,
   input  wire logic                       ptr_load,
   input  wire logic [PW-1:0]              ptr_load_val,
   input  wire logic                       ptr_inc,
   // Pointer state towards the core.
   output logic      [PW-1:0]              active_data_pointer_q,
   output logic                            pointer_select_q
);
   import ddp_pkg::*;

   localparam logic [PW-1:0] ONE = {{(PW-1){1'b0}}, 1'b1};

   // Control register fields and both pointers.
   logic                 sel_d;
   logic                 swap_q;
   logic                 swap_d;
   ddp_mode_e            mode_q [2];
   ddp_mode_e            mode_d [2];
   logic [PW-1:0]        ptr_q  [2];
   logic [PW-1:0]        ptr_d  [2];
   logic [PW-1:0]        step_nxt [2];
   logic [PW-1:0]        active_d;
   logic [SFR_DW-1:0]    rdata_d;
   logic                 hit_d;
   logic [SFR_DW-1:0]    ctl_view;
   logic [PW-1:0]        cur_ptr;
   logic                 qual_xfer;
   logic                 wr_ctl;
   logic                 wr_low;
   logic                 wr_high;
   logic                 wr_page;

   // One step unit per pointer; index 0 is the main pointer, index 1 the shadow.
   for (genvar i = 0; i < 2; i++) begin : g_step
      ddp_step_if #(.W(PW)) st_if ();
      assign st_if.mode  = mode_q[i];
      assign st_if.cur   = ptr_q[i];
      assign step_nxt[i] = st_if.nxt;
      ddp_step #(.W(PW)) u_step (
         .st (st_if)
      );
   end

   // Decode of the bus and of the instruction kind.
   assign wr_ctl    = sfr_wr && (sfr_addr == ADDR_PTR_CTL);
   assign wr_low    = sfr_wr && (sfr_addr == ADDR_PTR_LOW);
   assign wr_high   = sfr_wr && (sfr_addr == ADDR_PTR_HIGH);
   assign wr_page   = sfr_wr && (sfr_addr == ADDR_PTR_PAGE);
   assign qual_xfer = xfer_valid && ((xfer_kind == DDP_XFER_MOVC_ACTIVE_DATA_POINTER) ||
                                     (xfer_kind == DDP_XFER_MOVX_ACTIVE_DATA_POINTER));
   assign cur_ptr   = ptr_q[pointer_select_q];

   // Control register as software sees it; bits 7 and 1 are not stored and read zero.
   always_comb begin
      ctl_view                                     = CTL_RESET;
      ctl_view[CTL_SEL_BIT]                        = pointer_select_q;
      ctl_view[CTL_MMODE_LSB+1:CTL_MMODE_LSB]      = mode_q[0];
      ctl_view[CTL_SMODE_LSB+1:CTL_SMODE_LSB]      = mode_q[1];
      ctl_view[CTL_SWAP_BIT]                       = swap_q;
      ctl_view[CTL_UNUSED_BIT]                     = 1'b0;
      ctl_view[CTL_RSVD_BIT]                       = 1'b0;
   end

   // Next values of control fields and pointers.
   // Only one pointer changes per cycle: the selected one. A bus write to a
   // pointer byte beats a load, which beats an increment, which beats a move,
   // because the core never issues two of them in one instruction anyway.
   always_comb begin
      sel_d     = pointer_select_q;
      swap_d    = swap_q;
      mode_d[0] = mode_q[0];
      mode_d[1] = mode_q[1];
      ptr_d[0]  = ptr_q[0];
      ptr_d[1]  = ptr_q[1];

      if (wr_low) begin
         ptr_d[pointer_select_q][LOW_LSB+7:LOW_LSB] = sfr_wdata;
      end else if (wr_high) begin
         ptr_d[pointer_select_q][HIGH_LSB+7:HIGH_LSB] = sfr_wdata;
      end else if (wr_page) begin
         ptr_d[pointer_select_q][PAGE_LSB+7:PAGE_LSB] = sfr_wdata;
      end else if (ptr_load) begin
         ptr_d[pointer_select_q] = ptr_load_val;
      end else if (ptr_inc) begin
         ptr_d[pointer_select_q] = cur_ptr + ONE;
      end else if (qual_xfer) begin
         // The core has already used cur_ptr as the address; the step lands after it.
         ptr_d[pointer_select_q] = step_nxt[pointer_select_q];
      end

      // The swap follows the pointer update of the same move.
      if (qual_xfer && swap_q) begin
         sel_d = ~pointer_select_q;
      end

      // A control write wins over an automatic swap in the same cycle, so that
      // software always ends up with the select, mode and swap values it wrote.
      if (wr_ctl) begin
         sel_d     = sfr_wdata[CTL_SEL_BIT];
         mode_d[0] = ddp_mode_e'(sfr_wdata[CTL_MMODE_LSB+1:CTL_MMODE_LSB]);
         mode_d[1] = ddp_mode_e'(sfr_wdata[CTL_SMODE_LSB+1:CTL_SMODE_LSB]);
         swap_d    = sfr_wdata[CTL_SWAP_BIT];
      end

      active_d = ptr_d[sel_d];
   end

   // Read data comes from the state before this cycle's update.
   always_comb begin
      rdata_d = sfr_rdata_q;
      hit_d   = 1'b0;
      if (sfr_rd) begin
         hit_d = 1'b1;
         case (sfr_addr)
            ADDR_PTR_CTL:  rdata_d = ctl_view;
            ADDR_PTR_LOW:  rdata_d = cur_ptr[LOW_LSB+7:LOW_LSB];
            ADDR_PTR_HIGH: rdata_d = cur_ptr[HIGH_LSB+7:HIGH_LSB];
            ADDR_PTR_PAGE: rdata_d = cur_ptr[PAGE_LSB+7:PAGE_LSB];
            default: begin
               rdata_d = UNMAPPED_DATA;
               hit_d   = 1'b0;
            end
         endcase
      end
   end

   // Registers of the control fields and the read path.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pointer_select_q <= CTL_RESET[CTL_SEL_BIT];
         swap_q           <= CTL_RESET[CTL_SWAP_BIT];
         mode_q[0]        <= DDP_MODE_STD;
         mode_q[1]        <= DDP_MODE_STD;
         sfr_rdata_q      <= UNMAPPED_DATA;
         sfr_hit_q        <= 1'b0;
      end else begin
         pointer_select_q <= sel_d;
         swap_q           <= swap_d;
         mode_q[0]        <= mode_d[0];
         mode_q[1]        <= mode_d[1];
         sfr_rdata_q      <= rdata_d;
         sfr_hit_q        <= hit_d;
      end
   end

   // Registers of both pointers and the active copy the core addresses with.
   // Keeping a registered copy costs 24 flops but keeps the mux off the address path.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ptr_q[0]              <= PW'(PTR_RESET);
         ptr_q[1]              <= PW'(PTR_RESET);
         active_data_pointer_q <= PW'(PTR_RESET);
      end else begin
         ptr_q[0]              <= ptr_d[0];
         ptr_q[1]              <= ptr_d[1];
         active_data_pointer_q <= active_d;
      end
   end

endmodule

// ### testbench/ddp_monitor.sv
// Concurrent checks on the ports of the dual data pointer unit.
`timescale 1ns/1ps
module ddp_monitor
   import ddp_pkg::*;
#(
   parameter int PW = 24
) (
   // Clock and reset.
   input wire logic            sys_clk,
   input wire logic            rst_b,
   // Register bus.
   input wire logic [7:0]      sfr_addr,
   input wire logic            sfr_wr,
   input wire logic            sfr_rd,
   input wire logic [7:0]      sfr_wdata,
   input wire logic [7:0]      sfr_rdata_q,
   input wire logic            sfr_hit_q,
   // Instruction events and pointer state.
   input wire logic            xfer_valid,
   input wire ddp_xfer_e       xfer_kind,
   input wire logic            ptr_load,
   input wire logic [PW-1:0]   ptr_load_val,
   input wire logic            ptr_inc,
   input wire logic [PW-1:0]   active_data_pointer_q,
   input wire logic            pointer_select_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // A cycle with no register write and no direct pointer change, so only moves may act.
   logic mapped;
   logic quiet;
   assign mapped = sfr_addr inside {ADDR_PTR_CTL, ADDR_PTR_LOW, ADDR_PTR_HIGH, ADDR_PTR_PAGE};
   assign quiet = !sfr_wr && !ptr_load && !ptr_inc;
   // Named request shapes that the properties start from.
   sequence s_rd_map;
      sfr_rd && mapped;
   endsequence
   sequence s_inc_only;
      ptr_inc && !ptr_load && !sfr_wr && !xfer_valid;
   endsequence
   read_hit_a: assert property (s_rd_map |=> sfr_hit_q) else $error("mapped read not acknowledged");
   read_miss_a: assert property (sfr_rd && !mapped |=> !sfr_hit_q && sfr_rdata_q == 8'h00)
      else $error("unmapped read answered");
   hit_pulse_a: assert property (!sfr_rd |=> !sfr_hit_q) else $error("acknowledge without read");
   ctl_bits_a: assert property (sfr_rd && sfr_addr == ADDR_PTR_CTL |=> sfr_rdata_q[1] == 1'b0 && sfr_rdata_q[7] == 1'b0)
      else $error("absent control bit reads set");
   select_write_a: assert property (sfr_wr && sfr_addr == ADDR_PTR_CTL |=> pointer_select_q == $past(sfr_wdata[0]))
      else $error("select does not follow write");
   load_ptr_a: assert property (ptr_load && !sfr_wr && !xfer_valid |=> active_data_pointer_q == $past(ptr_load_val))
      else $error("load missed active pointer");
   inc_ptr_a: assert property (s_inc_only |=> active_data_pointer_q == $past(active_data_pointer_q) + PW'(1))
      else $error("increment wrong");
   other_kind_a: assert property (xfer_valid && xfer_kind[1] && quiet |=> $stable(active_data_pointer_q)
      && $stable(pointer_select_q)) else $error("non pointer move changed state");
   hold_state_a: assert property (!xfer_valid && quiet |=> $stable(active_data_pointer_q) && $stable(pointer_select_q))
      else $error("pointer state drifted");
endmodule
bind ddp_top ddp_monitor #(.PW(PW)) u_mon (.sys_clk(sys_clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .sfr_hit_q(sfr_hit_q), .xfer_valid(xfer_valid),
   .xfer_kind(xfer_kind), .ptr_load(ptr_load), .ptr_load_val(ptr_load_val), .ptr_inc(ptr_inc),
   .active_data_pointer_q(active_data_pointer_q), .pointer_select_q(pointer_select_q));

// ### testbench/ddp_core_model.sv
// Behavioural model of the core: register bus cycles and instruction events.
`timescale 1ns/1ps
module ddp_core_model
   import ddp_pkg::*;
(
   // Clock.
   input  wire logic       sys_clk,
   // Register bus.
   output logic [7:0]      sfr_addr,
   output logic            sfr_wr,
   output logic            sfr_rd,
   output logic [7:0]      sfr_wdata,
   input  wire logic [7:0] sfr_rdata_q,
   input  wire logic       sfr_hit_q,
   // Instruction events.
   output logic            xfer_valid,
   output ddp_xfer_e       xfer_kind,
   output logic            ptr_load,
   output logic [23:0]     ptr_load_val,
   output logic            ptr_inc
);
   // Idle bus from time zero.
   initial begin
      {sfr_addr, sfr_wr, sfr_rd, sfr_wdata, xfer_valid, ptr_load, ptr_load_val, ptr_inc} = '0;
      xfer_kind = DDP_XFER_MOVC_PC;
   end
   // Ends a one-cycle request; released lines flip so stale values are never mistaken for live ones.
   task done;
      @(posedge sys_clk);
      #1;
      {sfr_wr, sfr_rd, xfer_valid, ptr_load, ptr_inc} = '0;
      sfr_addr = ~sfr_addr;
      sfr_wdata = ~sfr_wdata;
      ptr_load_val = ~ptr_load_val;
   endtask
   // Software never sets the reserved top control bit.
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      sfr_addr = a;
      sfr_wdata = (a == ADDR_PTR_CTL) ? (d & 8'h7f) : d;
      sfr_wr = 1'b1;
      done;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d, output logic h);
      @(posedge sys_clk);
      #1;
      sfr_addr = a;
      sfr_rd = 1'b1;
      done;
      d = sfr_rdata_q;
      h = sfr_hit_q;
   endtask
   task mv(input ddp_xfer_e k);
      @(posedge sys_clk);
      #1;
      xfer_kind = k;
      xfer_valid = 1'b1;
      done;
   endtask
   task ld(input logic [23:0] v);
      @(posedge sys_clk);
      #1;
      ptr_load_val = v;
      ptr_load = 1'b1;
      done;
   endtask
   task inc;
      @(posedge sys_clk);
      #1;
      ptr_inc = 1'b1;
      done;
   endtask
endmodule

// ### testbench/test_dual_data_pointer_control.sv
// Self-checking testbench of the dual data pointer unit.
`timescale 1ns/1ps
module test_dual_data_pointer_control;
   import ddp_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, d;
   logic sfr_wr, sfr_rd, sfr_hit_q, xfer_valid, ptr_load, ptr_inc, pointer_select_q, h;
   ddp_xfer_e xfer_kind;
   logic [23:0] ptr_load_val, active_data_pointer_q;
   int n_fail = 0;
   int total_checks = 0;
   always #5 sys_clk = ~sys_clk;
   ddp_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .sfr_hit_q(sfr_hit_q), .xfer_valid(xfer_valid),
      .xfer_kind(xfer_kind), .ptr_load(ptr_load), .ptr_load_val(ptr_load_val), .ptr_inc(ptr_inc),
      .active_data_pointer_q(active_data_pointer_q), .pointer_select_q(pointer_select_q));
   ddp_core_model core (.sys_clk(sys_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .sfr_hit_q(sfr_hit_q), .xfer_valid(xfer_valid),
      .xfer_kind(xfer_kind), .ptr_load(ptr_load), .ptr_load_val(ptr_load_val), .ptr_inc(ptr_inc));
   // Four-state compare, so an unknown never passes.
   task chk(input logic [23:0] g, input logic [23:0] e);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task t_reset;
      core.rd(ADDR_PTR_CTL, d, h);
      chk({16'h0, d}, 24'h0);
      chk({23'h0, pointer_select_q}, 24'h0);
      chk(active_data_pointer_q, 24'h0);
   endtask
   // Increment of the register by read, add and write flips only the select bit.
   task t_ctl;
      core.wr(ADDR_PTR_CTL, 8'h7f);
      core.rd(ADDR_PTR_CTL, d, h);
      chk({15'h0, h, d}, 24'h17d);
      core.wr(ADDR_PTR_CTL, d + 8'h01);
      core.rd(ADDR_PTR_CTL, d, h);
      chk({15'h0, pointer_select_q, d}, 24'h07c);
      core.rd(8'h90, d, h);
      chk({15'h0, h, d}, 24'h0);
   endtask
   task t_ptrs;
      core.wr(ADDR_PTR_CTL, 8'h00);
      core.ld(24'h12ffff);
      core.wr(ADDR_PTR_CTL, 8'h01);
      core.ld(24'habcdef);
      chk(active_data_pointer_q, 24'habcdef);
      for (int i = 0; i < 3; i++) begin
         core.rd(8'(ADDR_PTR_LOW + i), d, h);
         chk({16'h0, d}, (24'habcdef >> (8 * i)) & 24'hff);
      end
      core.wr(ADDR_PTR_CTL, 8'h00);
      chk(active_data_pointer_q, 24'h12ffff);
      core.inc;
      chk(active_data_pointer_q, 24'h130000);
      core.wr(ADDR_PTR_CTL, 8'h01);
      chk(active_data_pointer_q, 24'habcdef);
   endtask
   // Every mode on each pointer against every move kind.
   task t_modes;
      logic [1:0] m;
      logic [23:0] e;
      for (int p = 0; p < 2; p++) for (int mi = 0; mi < 4; mi++) for (int k = 0; k < 4; k++) begin
         m = 2'(mi);
         core.wr(ADDR_PTR_CTL, p ? {2'b00, m, 4'h1} : {4'h0, m, 2'b00});
         core.ld(24'h010000);
         core.mv(ddp_xfer_e'(k));
         e = (k > 1 || m == 2'h0) ? 24'h010000 : (m == 2'h1) ? 24'h010001 : (m == 2'h2) ? 24'h00ffff : 24'h010001;
         chk(active_data_pointer_q, e);
      end
   endtask
   // Copy-loop shape: swap after each pointer move, update lands on the pointer used.
   task t_swap;
      core.wr(ADDR_PTR_CTL, 8'h00);
      core.ld(24'h0);
      core.wr(ADDR_PTR_CTL, 8'h55);
      core.ld(24'h00d000);
      core.mv(DDP_XFER_MOVC_ACTIVE_DATA_POINTER);
      chk({23'h0, pointer_select_q}, 24'h0);
      chk(active_data_pointer_q, 24'h0);
      core.mv(DDP_XFER_MOVX_ACTIVE_DATA_POINTER);
      chk({23'h0, pointer_select_q}, 24'h1);
      chk(active_data_pointer_q, 24'h00d001);
      core.mv(DDP_XFER_MOVX_RI);
      chk({23'h0, pointer_select_q}, 24'h1);
      core.wr(ADDR_PTR_CTL, 8'h15);
      core.mv(DDP_XFER_MOVC_ACTIVE_DATA_POINTER);
      chk({23'h0, pointer_select_q}, 24'h1);
      chk(active_data_pointer_q, 24'h00d002);
   endtask
   task end_of_test;
      if (n_fail == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      #200000;
      n_fail++;
      end_of_test;
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      t_reset;
      t_ctl;
      t_ptrs;
      t_modes;
      t_swap;
      end_of_test;
   end
endmodule
